// File: rtl/pef_pkg.sv
// Constants and register map for the first peripheral event flag register
// ============================================================================
// Summary of operation
// - Each flag is set by its event whatever the enable and global enable bits say.
// - Every peripheral source owns one flag bit that no other source shares.
// - The peripheral flags are split over two registers and this block holds the first.
// - The converter flag is set when a conversion finishes and holds until software clears it.
// - The timer two flag is set when the count equals the period and holds until cleared.
// - The timer one flag is set on count overflow and holds until software writes it to zero.
// - The capture/compare one flag is set on a capture or compare match and holds until cleared.
package pef_pkg;
   // ========================================================================
   // Register byte addresses
   localparam logic [3:0] ADDR_FLAGS    = 4'h0;
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;
   // ========================================================================
   // Flag bit positions
   localparam int BIT_PSP  = 7;
   localparam int BIT_ADC  = 6;
   localparam int BIT_RX   = 5;
   localparam int BIT_TX   = 4;
   localparam int BIT_SSP  = 3;
   localparam int BIT_CCP1 = 2;
   localparam int BIT_TIMER_TWO_COUNT = 1;
   localparam int BIT_TIMER_ONE_COUNT = 0;
   localparam int NUM_FLAGS = 8;
   // ========================================================================
   // Reset values and masks
   localparam logic [7:0] FLAGS_RESET   = 8'h00;
   localparam logic [7:0] MASK_RESET    = 8'h00;
   localparam logic [7:0] WRITABLE_MASK = 8'hCF;
   // ========================================================================
   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: rtl/pef_sticky_bit.sv
// One sticky flag with set-over-clear priority
`timescale 1ns/1ps
module pef_sticky_bit
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // Control
   input  wire logic setEvt,
   input  wire logic clrEvt,
   // State
   output logic      flag
);
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         flag <= 1'b0;
      else if (setEvt)
         flag <= 1'b1;
      else if (clrEvt)
         flag <= 1'b0;
   end
endmodule // pef_sticky_bit

// File: rtl/pef_flags_one.sv
// First peripheral event flag register with AXI4-Lite slave and interrupt
`timescale 1ns/1ps
module pef_flags_one
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // AXI4-Lite write address
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [3:0]  s_axi_awaddr,
   // AXI4-Lite write data
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // AXI4-Lite write response
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   // AXI4-Lite read address
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [3:0]  s_axi_araddr,
   // AXI4-Lite read data
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   // Peripheral event pulses
   input  wire logic        pspDoneEvt,
   input  wire logic        adcDoneEvt,
   input  wire logic        sspDoneEvt,
   input  wire logic        ccp1Evt,
   input  wire logic        tmr2MatchEvt,
   input  wire logic        tmr1OvfEvt,
   // Serial buffer levels
   input  wire logic        rxBufFull,
   input  wire logic        txBufEmpty,
   // Flag view for the core priority logic
   output logic [7:0]       peripheralEventFlagsOne,
   // Interrupt
   output logic             irq
);
   // ========================================================================
   // Address decode
   function automatic logic isAddr(input logic [3:0] a, input logic [3:0] r);
      isAddr = (a[3:2] == r[3:2]);
   endfunction

   logic       awHeld_r;
   logic [3:0] awAddr_r;
   logic       wHeld_r;
   logic [31:0] wData_r;
   logic [3:0] wStrb_r;
   logic       doWrite;
   logic       wrFlags;
   logic       wrStat;
   logic       wrMask;
   logic [7:0] flags;
   logic [7:0] flagSet;
   logic [7:0] flagClr;
   logic [7:0] irqStat_r;
   logic [7:0] irqMask_r;
   logic [7:0] prevFlags_r;
   logic [7:0] wByte;

   assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
   assign wByte   = wData_r[7:0];
   assign wrFlags = doWrite && wStrb_r[0] && isAddr(awAddr_r, pef_pkg::ADDR_FLAGS);
   assign wrStat  = doWrite && wStrb_r[0] && isAddr(awAddr_r, pef_pkg::ADDR_IRQ_STAT);
   assign wrMask  = doWrite && wStrb_r[0] && isAddr(awAddr_r, pef_pkg::ADDR_IRQ_MASK);

   // ========================================================================
   // Write channel capture, either order
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         awHeld_r      <= 1'b0;
         awAddr_r      <= 4'h0;
         s_axi_awready <= 1'b0;
      end
      else
      begin
         s_axi_awready <= !awHeld_r && !s_axi_awready && s_axi_awvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHeld_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
         end
         else if (doWrite)
            awHeld_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         wHeld_r      <= 1'b0;
         wData_r      <= 32'h0000_0000;
         wStrb_r      <= 4'h0;
         s_axi_wready <= 1'b0;
      end
      else
      begin
         s_axi_wready <= !wHeld_r && !s_axi_wready && s_axi_wvalid;
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHeld_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end
         else if (doWrite)
            wHeld_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= pef_pkg::RESP_OKAY;
      end
      else if (doWrite)
      begin
         s_axi_bvalid <= 1'b1;
         if (isAddr(awAddr_r, pef_pkg::ADDR_FLAGS) || isAddr(awAddr_r, pef_pkg::ADDR_IRQ_STAT)
             || isAddr(awAddr_r, pef_pkg::ADDR_IRQ_MASK))
            s_axi_bresp <= pef_pkg::RESP_OKAY;
         else
            s_axi_bresp <= pef_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // ========================================================================
   // Flag set and clear terms
   always_comb
   begin
      flagSet = 8'h00;
      flagClr = 8'h00;
      // Events set regardless of any enable
      flagSet[pef_pkg::BIT_PSP]  = pspDoneEvt;
      flagSet[pef_pkg::BIT_ADC]  = adcDoneEvt;
      flagSet[pef_pkg::BIT_SSP]  = sspDoneEvt;
      flagSet[pef_pkg::BIT_CCP1] = ccp1Evt;
      flagSet[pef_pkg::BIT_TIMER_TWO_COUNT] = tmr2MatchEvt;
      flagSet[pef_pkg::BIT_TIMER_ONE_COUNT] = tmr1OvfEvt;
      // Software writes zero to clear writable bits
      if (wrFlags)
         flagClr = ~wByte & pef_pkg::WRITABLE_MASK;
   end

   // One sticky cell per event source, none for the buffer bits 5 and 4
   genvar gi;
   generate
      for (gi = 0; gi < pef_pkg::NUM_FLAGS; gi++)
      begin : gSticky
         if (gi == pef_pkg::BIT_RX || gi == pef_pkg::BIT_TX)
         begin : gLevel
            logic unusedSet;
            assign unusedSet = flagSet[gi] | flagClr[gi];
         end
         else
         begin : gCell
            pef_sticky_bit uBit
            (
               .clk    (clk),
               .reset  (reset),
               .setEvt (flagSet[gi]),
               .clrEvt (flagClr[gi]),
               .flag   (flags[gi])
            );
         end
      end
   endgenerate

   // Buffer-following flags, read-only
   assign flags[pef_pkg::BIT_RX] = rxBufFull;
   assign flags[pef_pkg::BIT_TX] = txBufEmpty;

   // ========================================================================
   // Flag view register, one cycle behind the cells
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         peripheralEventFlagsOne <= pef_pkg::FLAGS_RESET;
      else
         peripheralEventFlagsOne <= flags;   // First of the two flag registers
   end

   // ========================================================================
   // Interrupt status: rising flag sets, write one clears, set wins
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         prevFlags_r <= pef_pkg::FLAGS_RESET;
      else
         prevFlags_r <= flags;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         irqStat_r <= 8'h00;
      else
         irqStat_r <= (flags & ~prevFlags_r) | (irqStat_r & ~(wrStat ? wByte : 8'h00));
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         irqMask_r <= pef_pkg::MASK_RESET;
      else if (wrMask)
         irqMask_r <= wByte;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         irq <= 1'b0;
      else
         irq <= |(irqStat_r & irqMask_r);
   end

   // ========================================================================
   // Read channel
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= pef_pkg::RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= pef_pkg::RESP_OKAY;
            if (isAddr(s_axi_araddr, pef_pkg::ADDR_FLAGS))
               s_axi_rdata <= {24'h000000, flags};
            else if (isAddr(s_axi_araddr, pef_pkg::ADDR_IRQ_STAT))
               s_axi_rdata <= {24'h000000, irqStat_r};
            else if (isAddr(s_axi_araddr, pef_pkg::ADDR_IRQ_MASK))
               s_axi_rdata <= {24'h000000, irqMask_r};
            else
            begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= pef_pkg::RESP_SLVERR;
            end
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
endmodule // pef_flags_one

// File: verif/pef_periph_model.sv
// Behavioural model of the peripherals that raise events and buffer levels
`timescale 1ns/1ps
module pef_periph_model
(
   // Clock
   input  wire logic       clk,
   // Event pulses in flag bit order, bits 5 and 4 are buffer levels
   output logic [7:0]      evt
);
   initial evt = 8'h00;
   // ========================================================================
   // Stimulus tasks
   task automatic pulse(input int b);
      @(posedge clk);
      evt[b] <= 1'b1;
      @(posedge clk);
      evt[b] <= 1'b0;
   endtask
   task automatic levels(input logic rx, input logic tx);
      @(posedge clk);
      evt[5:4] <= {rx, tx};
   endtask
endmodule // pef_periph_model

// File: verif/pef_flags_one_props.sv
// Assertion checker for the first peripheral event flag register
`timescale 1ns/1ps
module pef_flags_one_props
(
   // Clock and reset
   input wire logic       clk,
   input wire logic       reset,
   // Bus response
   input wire logic       s_axi_bvalid,
   // Events and levels
   input wire logic       pspDoneEvt,
   input wire logic       adcDoneEvt,
   input wire logic       sspDoneEvt,
   input wire logic       ccp1Evt,
   input wire logic       tmr2MatchEvt,
   input wire logic       tmr1OvfEvt,
   input wire logic       rxBufFull,
   input wire logic       txBufEmpty,
   // Flag view
   input wire logic [7:0] peripheralEventFlagsOne
);
   logic [7:0] f;
   assign f = peripheralEventFlagsOne;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // ========================================================================
   // Properties
   property p_psp; pspDoneEvt |=> ##1 f[7]; endproperty
   a_psp: assert property (p_psp) else $error("port flag not set");
   property p_adc; adcDoneEvt |=> ##1 f[6]; endproperty
   a_adc: assert property (p_adc) else $error("converter flag not set");
   property p_ssp; sspDoneEvt |=> ##1 f[3]; endproperty
   a_ssp: assert property (p_ssp) else $error("sync flag not set");
   property p_ccp; ccp1Evt |=> ##1 f[2]; endproperty
   a_ccp: assert property (p_ccp) else $error("ccp flag not set");
   property p_tm2; tmr2MatchEvt |=> ##1 f[1]; endproperty
   a_tm2: assert property (p_tm2) else $error("timer2 flag not set");
   property p_tm1; tmr1OvfEvt |=> ##1 f[0]; endproperty
   a_tm1: assert property (p_tm1) else $error("timer1 flag not set");
   property p_lvl; !reset ##1 !reset |-> f[5:4] == $past({rxBufFull, txBufEmpty}); endproperty
   a_lvl: assert property (p_lvl) else $error("buffer flags wrong");
   property p_hold; |($past(f) & ~f & 8'hCF) |-> $past(s_axi_bvalid); endproperty
   a_hold: assert property (p_hold) else $error("flag fell without write");
endmodule // pef_flags_one_props
bind pef_flags_one pef_flags_one_props u_props (.clk(clk), .reset(reset),
   .s_axi_bvalid(s_axi_bvalid), .pspDoneEvt(pspDoneEvt), .adcDoneEvt(adcDoneEvt),
   .sspDoneEvt(sspDoneEvt), .ccp1Evt(ccp1Evt), .tmr2MatchEvt(tmr2MatchEvt),
   .tmr1OvfEvt(tmr1OvfEvt), .rxBufFull(rxBufFull), .txBufEmpty(txBufEmpty),
   .peripheralEventFlagsOne(peripheralEventFlagsOne));

// File: verif/pef_flags_one_tb_top.sv
// Self-checking bench for the first peripheral event flag register
`timescale 1ns/1ps
module pef_flags_one_tb_top;
   localparam logic [3:0] AF = pef_pkg::ADDR_FLAGS;
   localparam logic [3:0] AS = pef_pkg::ADDR_IRQ_STAT;
   localparam logic [3:0] AM = pef_pkg::ADDR_IRQ_MASK;
   localparam logic [1:0] OK = pef_pkg::RESP_OKAY;
   localparam logic [1:0] ER = pef_pkg::RESP_SLVERR;
   logic        clk, reset, irq;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [3:0]  awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic [7:0]  evt, flagsOut, ex;
   int          numErrors, nTests, cycles;
   int          evBits[6] = '{7, 6, 3, 2, 1, 0};
   pef_periph_model PM (.clk(clk), .evt(evt));
   pef_flags_one DUT (.clk(clk), .reset(reset),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .pspDoneEvt(evt[7]), .adcDoneEvt(evt[6]), .sspDoneEvt(evt[3]), .ccp1Evt(evt[2]),
      .tmr2MatchEvt(evt[1]), .tmr1OvfEvt(evt[0]), .rxBufFull(evt[5]), .txBufEmpty(evt[4]),
      .peripheralEventFlagsOne(flagsOut), .irq(irq));
   // ========================================================================
   // Clock and timeout
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         numErrors++;
         conclude();
      end
   end
   // ========================================================================
   // Bus tasks
   task automatic check(input string w, input logic [31:0] seen, input logic [31:0] e);
      nTests++;
      if (seen !== e)
      begin
         numErrors++;
         $display("[ERR] %s expected %h seen %h", w, e, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s,
                     input logic [1:0] r);
      @(posedge clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= {24'h000000, d};
      wstrb <= s;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while ((awvalid && !awready) || (wvalid && !wready));
      do @(posedge clk); while (!bvalid);
      bready <= 1'b0;
      check("bresp", 32'(bresp), 32'(r));
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk); while (!rvalid);
      rready <= 1'b0;
      check("rresp", 32'(rresp), 32'(r));
      check("rdata", rdata, 32'(e));
   endtask
   task automatic chkIrq(input logic e);
      repeat (4) @(posedge clk);
      check("irq", 32'(irq), 32'(e));
   endtask
   task automatic conclude();
      $display("Comparisons %0d mismatches %0d", nTests, numErrors);
      if (numErrors == 0 && nTests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // ========================================================================
   // Test sequence
   initial
   begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wstrb} = 12'h000;
      wdata = 32'h0;
      reset = 1'b1;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      rd(AF, 8'h00, OK);
      rd(AS, 8'h00, OK);
      rd(AM, 8'h00, OK);
      $display("Test reset done");
      ex = 8'h00;
      foreach (evBits[i])
      begin
         PM.pulse(evBits[i]);
         ex[evBits[i]] = 1'b1;
         rd(AF, ex, OK);
         check("flagsOut", 32'(flagsOut), 32'(ex));
         check("irq", 32'(irq), 32'h0);
      end
      $display("Test events done");
      wr(AF, 8'hFF, 4'hF, OK);
      rd(AF, 8'hCF, OK);
      wr(AF, 8'h00, 4'h0, OK);
      rd(AF, 8'hCF, OK);
      wr(AF, 8'hBF, 4'hF, OK);
      rd(AF, 8'h8F, OK);
      wr(AF, 8'h00, 4'hF, OK);
      rd(AF, 8'h00, OK);
      $display("Test clear done");
      PM.levels(1'b1, 1'b1);
      rd(AF, 8'h30, OK);
      wr(AF, 8'h00, 4'hF, OK);
      rd(AF, 8'h30, OK);
      PM.levels(1'b0, 1'b0);
      rd(AF, 8'h00, OK);
      $display("Test buffers done");
      rd(AS, 8'hFF, OK);
      wr(AS, 8'hFF, 4'hF, OK);
      wr(AM, 8'h01, 4'hF, OK);
      rd(AM, 8'h01, OK);
      chkIrq(1'b0);
      PM.pulse(0);
      chkIrq(1'b1);
      wr(AS, 8'h01, 4'hF, OK);
      chkIrq(1'b0);
      rd(AS, 8'h00, OK);
      $display("Test interrupt done");
      wr(4'hC, 8'hFF, 4'hF, ER);
      rd(4'hC, 8'h00, ER);
      $display("Test unmapped done");
      conclude();
   end
endmodule // pef_flags_one_tb_top
